// *** logic/ubd_consts.svh ***
`ifndef UBD_CONSTS_SVH
`define UBD_CONSTS_SVH
// ==========================================
// register byte addresses
`define UBD_OFS_RX   8'h00
`define UBD_OFS_TX   8'h04
`define UBD_OFS_DIVL 8'h08
`define UBD_OFS_DIVH 8'h0C
`define UBD_OFS_TXC  8'h10
`define UBD_OFS_RXS  8'h14
`define UBD_OFS_BCTL 8'h18
// ==========================================
// field positions
`define UBD_TXC_NINTH 0
`define UBD_TXC_PEND  1
`define UBD_TXC_HS    2
`define UBD_TXC_SYNC  4
`define UBD_RXS_NINTH 0
`define UBD_RXS_FULL  1
`define UBD_BCTL_WIDE 3
// ==========================================
// generator periods per bit
`define UBD_FAC_LOW8 7'h40
`define UBD_FAC_MID  7'h10
`define UBD_FAC_FAST 7'h04
`define UBD_ZERO_BYTE 8'h00
`define UBD_ZERO_CNT  16'h0000
`define UBD_ONE_CNT   16'h0001
`define UBD_ONE_PRE   7'h01
`endif

// *** logic/ubd_pkg.sv ***
package ubd_pkg;
   // ==========================================
   // types
   typedef struct packed {
      logic       ninth;
      logic [7:0] data;
   } ubd_char_s;

   typedef enum logic [1:0] {
      UBD_MODE_LOW8 = 2'b00,
      UBD_MODE_MID  = 2'b01,
      UBD_MODE_FAST = 2'b10
   } ubd_mode_e;

   typedef struct packed {
      logic [7:0]  tx_data;
      logic        tx_ninth_bit;
      logic        tx_pend;
      logic [7:0]  rx_data;
      logic        rx_ninth_bit;
      logic        rx_full;
      logic [7:0]  baud_div_low;
      logic [7:0]  baud_div_high;
      logic        wide_divider_sel;
      logic        high_speed_sel;
      logic        sync_mode;
      logic [15:0] brg_cnt;
      logic [6:0]  pre_cnt;
      logic        brg_tick;
      logic        bit_tick;
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic [31:0] rdata;
   } ubd_state_s;
endpackage : ubd_pkg

// *** logic/ubd_core.sv ***
`timescale 1ns/1ps
`include "ubd_consts.svh"
// Contract
// - received low byte readable, ninth in status
// - received character double buffered with ninth
// - transmit byte register, resets zero, ninth elsewhere
// - transmit double buffered, reload once shifting
// - low divisor write restarts generator counter
// - high divisor write restarts generator counter
// - high divisor ignored unless wide select
// - async narrow low speed divides by 64
// - async wide low speed divides by 16
// - synchronous ignores speed select, divides by 4
// - divisor is high byte over low byte
// - wide select picks 16 or 8 bit counter
// - mode select picks sync or async formula
module ubd_core
   import ubd_pkg::*;
(
   input  wire logic        i_ref_clk,   // core clock
   input  wire logic        i_sys_rst,   // sync reset, high
   input  wire logic        i_hsel,      // slave select
   input  wire logic [31:0] i_haddr,     // address
   input  wire logic [1:0]  i_htrans,    // transfer type
   input  wire logic        i_hwrite,    // write
   input  wire logic [2:0]  i_hsize,     // size, word only
   input  wire logic [31:0] i_hwdata,    // write data
   input  wire logic        i_hready,    // bus ready
   output logic      [31:0] o_hrdata,    // read data
   output logic             o_hreadyout, // slave ready
   output logic             o_hresp,     // response
   input  wire logic        i_rx_done,   // shifter char done
   input  wire ubd_char_s   i_rx_char,   // shifter char
   input  wire logic        i_tx_load,   // shifter takes char
   output logic             o_tx_valid,  // char waiting
   output ubd_char_s        o_tx_char,   // char to shift
   output logic             o_rx_full,   // unread char held
   output logic             o_sync_mode, // clock mode select
   output logic             o_brg_tick,  // generator period
   output logic             o_bit_tick   // one bit time
);

   // ==========================================
   // state and decode
   ubd_state_s  s_q;
   ubd_state_s  s_d;
   logic        acc;
   logic        rd_acc;
   logic        tx_wr;
   logic        lo_wr;
   logic        hi_wr;
   logic        div_wr;
   logic [15:0] div_eff;
   ubd_mode_e   mode;
   logic [6:0]  fac;

   // size is not checked: only whole words are issued
   assign acc    = i_hsel & i_htrans[1] & i_hready;
   assign rd_acc = acc & ~i_hwrite;
   assign tx_wr  = s_q.wr_pend & (s_q.wr_addr == `UBD_OFS_TX);
   assign lo_wr  = s_q.wr_pend & (s_q.wr_addr == `UBD_OFS_DIVL);
   assign hi_wr  = s_q.wr_pend & (s_q.wr_addr == `UBD_OFS_DIVH);
   assign div_wr = lo_wr | hi_wr;

   assign div_eff = s_q.wide_divider_sel ? {s_q.baud_div_high, s_q.baud_div_low}
                                         : {`UBD_ZERO_BYTE, s_q.baud_div_low};

   always_comb begin
      if (s_q.sync_mode) begin
         mode = UBD_MODE_FAST;
      end else if (s_q.wide_divider_sel & s_q.high_speed_sel) begin
         mode = UBD_MODE_FAST;
      end else if (s_q.wide_divider_sel | s_q.high_speed_sel) begin
         mode = UBD_MODE_MID;
      end else begin
         mode = UBD_MODE_LOW8;
      end
   end

   always_comb begin
      case (mode)
         UBD_MODE_LOW8: fac = `UBD_FAC_LOW8;
         UBD_MODE_MID:  fac = `UBD_FAC_MID;
         UBD_MODE_FAST: fac = `UBD_FAC_FAST;
         default:       fac = `UBD_FAC_LOW8;
      endcase
   end

   function automatic logic [31:0] rd_word(input ubd_state_s st, input logic [7:0] a);
      logic [31:0] w;
      w = '0;
      case (a)
         `UBD_OFS_RX:   w[7:0] = st.rx_data;
         `UBD_OFS_TX:   w[7:0] = st.tx_data;
         `UBD_OFS_DIVL: w[7:0] = st.baud_div_low;
         `UBD_OFS_DIVH: w[7:0] = st.baud_div_high;
         `UBD_OFS_TXC: begin
            w[`UBD_TXC_NINTH] = st.tx_ninth_bit;
            w[`UBD_TXC_PEND]  = st.tx_pend;
            w[`UBD_TXC_HS]    = st.high_speed_sel;
            w[`UBD_TXC_SYNC]  = st.sync_mode;
         end
         `UBD_OFS_RXS: begin
            w[`UBD_RXS_NINTH] = st.rx_ninth_bit;
            w[`UBD_RXS_FULL]  = st.rx_full;
         end
         `UBD_OFS_BCTL: w[`UBD_BCTL_WIDE] = st.wide_divider_sel;
         default:       w = '0;
      endcase
      return w;
   endfunction : rd_word

   // ==========================================
   // next state
   always_comb begin
      s_d          = s_q;
      s_d.brg_tick = 1'b0;
      s_d.bit_tick = 1'b0;
      // address phase; read data is sampled here so the data phase needs no wait
      s_d.wr_pend  = acc & i_hwrite;
      if (acc) begin
         s_d.wr_addr = i_haddr[7:0];
      end
      if (rd_acc) begin
         s_d.rdata = rd_word(s_q, i_haddr[7:0]);
         if (i_haddr[7:0] == `UBD_OFS_RX) begin
            s_d.rx_full = 1'b0;
         end
      end
      // data phase writes
      if (s_q.wr_pend) begin
         case (s_q.wr_addr)
            `UBD_OFS_DIVL: s_d.baud_div_low  = i_hwdata[7:0];
            `UBD_OFS_DIVH: s_d.baud_div_high = i_hwdata[7:0];
            `UBD_OFS_TXC: begin
               s_d.tx_ninth_bit   = i_hwdata[`UBD_TXC_NINTH];
               s_d.high_speed_sel = i_hwdata[`UBD_TXC_HS];
               s_d.sync_mode      = i_hwdata[`UBD_TXC_SYNC];
            end
            `UBD_OFS_BCTL: s_d.wide_divider_sel = i_hwdata[`UBD_BCTL_WIDE];
            default: s_d.wr_addr = s_d.wr_addr;
         endcase
      end
      if (i_tx_load & s_q.tx_pend) begin
         s_d.tx_pend = 1'b0;
      end
      // transmit byte written
      // a write in the take cycle stays pending: set beats clear
      if (tx_wr) begin
         s_d.tx_data = i_hwdata[7:0];
         s_d.tx_pend = 1'b1;
      end
      // capture finished char
      // an unread char is overwritten; no overrun is flagged
      if (i_rx_done) begin
         s_d.rx_data      = i_rx_char.data;
         s_d.rx_ninth_bit = i_rx_char.ninth;
         s_d.rx_full      = 1'b1;
      end
      if (div_wr) begin
         s_d.brg_cnt = s_d.wide_divider_sel ? {s_d.baud_div_high, s_d.baud_div_low}
                                            : {`UBD_ZERO_BYTE, s_d.baud_div_low};
         s_d.pre_cnt = '0;
      end else if (s_q.brg_cnt == `UBD_ZERO_CNT) begin
         s_d.brg_cnt  = div_eff;
         s_d.brg_tick = 1'b1;
         // >= so a mode change to a smaller factor cannot strand the count
         if (s_q.pre_cnt >= fac - `UBD_ONE_PRE) begin
            s_d.pre_cnt  = '0;
            s_d.bit_tick = 1'b1;
         end else begin
            s_d.pre_cnt = s_q.pre_cnt + `UBD_ONE_PRE;
         end
      end else begin
         s_d.brg_cnt = s_q.brg_cnt - `UBD_ONE_CNT;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================
   // outputs
   // read data path
   assign o_hrdata     = s_q.rdata;
   assign o_hreadyout  = 1'b1;
   assign o_hresp      = 1'b0;
   assign o_tx_valid   = s_q.tx_pend;
   assign o_tx_char    = '{ninth: s_q.tx_ninth_bit, data: s_q.tx_data};
   assign o_rx_full    = s_q.rx_full;
   assign o_sync_mode  = s_q.sync_mode;
   assign o_brg_tick   = s_q.brg_tick;
   assign o_bit_tick   = s_q.bit_tick;

   // ==========================================
   // checks
   a_rx_read_back: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (rd_acc && i_haddr[7:0] == `UBD_OFS_RX) |=> o_hrdata == {24'h000000, $past(s_q.rx_data)})
      else $error("receive byte not returned on read");

   a_rx_capture: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_rx_done |=> (s_q.rx_data == $past(i_rx_char.data)) && (s_q.rx_ninth_bit == $past(i_rx_char.ninth))
                    && s_q.rx_full)
      else $error("received char not held");

   a_tx_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      tx_wr |=> (o_tx_char.data == $past(i_hwdata[7:0])) && o_tx_valid)
      else $error("transmit byte not stored");

   a_tx_take: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_tx_load && o_tx_valid && !tx_wr) |=> !o_tx_valid)
      else $error("buffer not freed after take");

   a_low_restart: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      lo_wr |=> (s_q.brg_cnt == div_eff) && (s_q.pre_cnt == 7'h00) && !o_brg_tick)
      else $error("low write did not restart counter");

   a_high_restart: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      hi_wr |=> (s_q.brg_cnt == div_eff) && (s_q.pre_cnt == 7'h00) && !o_brg_tick)
      else $error("high write did not restart counter");

   a_high_ignored: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      !s_q.wide_divider_sel |-> div_eff == {8'h00, s_q.baud_div_low})
      else $error("high byte used in narrow mode");

   a_rate_low8: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (!s_q.sync_mode && !s_q.wide_divider_sel && !s_q.high_speed_sel) |-> fac == 7'h40)
      else $error("narrow low speed factor wrong");

   a_rate_wide: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (!s_q.sync_mode && s_q.wide_divider_sel && !s_q.high_speed_sel) |-> fac == 7'h10)
      else $error("wide low speed factor wrong");

   a_rate_sync: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      s_q.sync_mode |-> fac == 7'h04)
      else $error("sync factor wrong");

   a_div_concat: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      s_q.wide_divider_sel |-> div_eff == {s_q.baud_div_high, s_q.baud_div_low})
      else $error("divisor halves misordered");

   a_bit_due: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (s_q.brg_cnt == 16'h0000 && !div_wr && s_q.pre_cnt == fac - 7'h01) |=> o_bit_tick && o_brg_tick)
      else $error("bit tick missed");

   a_brg_reload: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (s_q.brg_cnt == 16'h0000 && !div_wr) |=> o_brg_tick && (s_q.brg_cnt == $past(div_eff)))
      else $error("counter did not reload");

   a_rx_clear: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (rd_acc && i_haddr[7:0] == `UBD_OFS_RX && !i_rx_done) |=> !o_rx_full)
      else $error("receive full flag not cleared by read");

   a_rx_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      !i_rx_done |=> $stable(s_q.rx_data) && $stable(s_q.rx_ninth_bit))
      else $error("held receive char changed");

   a_tx_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      !tx_wr |=> $stable(o_tx_char.data))
      else $error("transmit byte changed without write");

   a_tx_pend_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (!i_tx_load && !tx_wr) |=> $stable(o_tx_valid))
      else $error("transmit pending changed without cause");

   a_low_store: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      lo_wr |=> s_q.baud_div_low == $past(i_hwdata[7:0]))
      else $error("low divisor not stored");

   a_high_store: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      hi_wr |=> s_q.baud_div_high == $past(i_hwdata[7:0]))
      else $error("high divisor not stored");

   a_rate_narrow_fast: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (!s_q.sync_mode && !s_q.wide_divider_sel && s_q.high_speed_sel) |-> fac == 7'h10)
      else $error("narrow high speed factor wrong");

   a_rate_wide_fast: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (!s_q.sync_mode && s_q.wide_divider_sel && s_q.high_speed_sel) |-> fac == 7'h04)
      else $error("wide high speed factor wrong");

   a_brg_count: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (s_q.brg_cnt != 16'h0000 && !div_wr) |=> (s_q.brg_cnt == $past(s_q.brg_cnt) - 16'h0001) && !o_brg_tick)
      else $error("counter did not count down");

   a_bit_with_brg: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      o_bit_tick |-> o_brg_tick)
      else $error("bit tick outside generator period");

endmodule : ubd_core

// *** verif/ubd_shifter_model.sv ***
`timescale 1ns/1ps
// ==========================================
// stand-in for the shift registers
module ubd_shifter_model
   import ubd_pkg::*;
(
   input  wire logic      i_ref_clk,  // core clock
   input  wire logic      i_sys_rst,  // sync reset
   input  wire logic      i_send,     // deliver one char
   input  wire ubd_char_s i_char,     // char to deliver
   input  wire logic      i_take_en,  // shifter may take
   input  wire logic      i_tx_valid, // buffer holds char
   input  wire ubd_char_s i_tx_char,  // buffered char
   output logic           o_rx_done,  // char finished
   output ubd_char_s      o_rx_char,  // finished char
   output logic           o_tx_load,  // take strobe
   output ubd_char_s      o_taken     // last char taken
);
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_rx_done <= 1'b0;
         o_rx_char <= '0;
         o_tx_load <= 1'b0;
         o_taken   <= '0;
      end else begin
         o_rx_done <= i_send;
         // outside the strobe the char lines carry junk: the old char and its inverse, by turns each cycle
         o_rx_char <= i_send ? i_char : ~o_rx_char;
         o_tx_load <= i_take_en & i_tx_valid & ~o_tx_load;
         if (o_tx_load) begin
            o_taken <= i_tx_char;
         end
      end
   end
endmodule : ubd_shifter_model

// *** verif/ubd_core_tb.sv ***
`timescale 1ns/1ps
`include "ubd_consts.svh"
module ubd_core_tb
   import ubd_pkg::*;
;
   logic clk, rst, hsel, hwrite, send, take_en, rx_done, tx_load;
   logic tx_valid, rx_full, sync_m, brg_tick, bit_tick, hrdy, hresp;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, v;
   ubd_char_s schar, rx_char, tx_char, taken;
   int err_total, n_checks, n, i;
   int fac[6] = '{64, 16, 4, 4, 16, 4};
   logic [7:0] txc[6] = '{8'h00, 8'h00, 8'h14, 8'h10, 8'h04, 8'h04};
   ubd_core ubd_core_inst (.i_ref_clk(clk), .i_sys_rst(rst), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
      .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy),
      .o_hresp(hresp), .i_rx_done(rx_done), .i_rx_char(rx_char), .i_tx_load(tx_load),
      .o_tx_valid(tx_valid), .o_tx_char(tx_char), .o_rx_full(rx_full),
      .o_sync_mode(sync_m), .o_brg_tick(brg_tick), .o_bit_tick(bit_tick));
   ubd_shifter_model ubd_shifter_model_inst (.i_ref_clk(clk), .i_sys_rst(rst),
      .i_send(send), .i_char(schar), .i_take_en(take_en), .i_tx_valid(tx_valid),
      .i_tx_char(tx_char), .o_rx_done(rx_done), .o_rx_char(rx_char),
      .o_tx_load(tx_load), .o_taken(taken));
   // ==========================================
   // helpers
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic hang;
      err_total++;
      $display("MISMATCH t=%0t wait ran out", $time);
      final_report();
   endtask : hang
   task automatic rdy;
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hrdy !== 1'b1 && k < 16);
      if (hrdy !== 1'b1) hang();
   endtask : rdy
   // one idle cycle before each transfer keeps a read off a fresh write
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      rdy();
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      v = hrdata;
      // outputs launched by the data phase edge are looked at once settled
      @(negedge clk);
   endtask : bus
   task automatic gap(input logic bt);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while ((bt ? bit_tick : brg_tick) !== 1'b1 && n < 9000);
      if (n >= 9000) hang();
   endtask : gap
   task automatic give(input logic [8:0] c);
      @(posedge clk);
      send <= 1'b1;
      schar <= c;
      @(posedge clk);
      send <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : give
   // ==========================================
   // scenarios
   task automatic t_reset;
      foreach (fac[j]) begin
         bus(1'b0, 8'(j * 4), 32'h0);
         chk(v, 32'h0);
      end
      bus(1'b0, 8'h1C, 32'h0);
      chk(v, 32'h0);
      chk(hresp, 32'h0);
      $display("reset values done");
   endtask : t_reset
   task automatic t_tx;
      bus(1'b1, `UBD_OFS_TXC, 32'h1);
      bus(1'b1, `UBD_OFS_TX, 32'hA5);
      chk({tx_valid, tx_char}, 32'h3A5);
      @(posedge clk);
      take_en <= 1'b1;
      for (i = 0; i < 20 && tx_valid === 1'b1; i++) @(posedge clk);
      take_en <= 1'b0;
      if (tx_valid === 1'b1) hang();
      chk(taken, 32'h1A5);
      bus(1'b1, `UBD_OFS_TX, 32'h5A);
      chk({tx_valid, tx_char}, 32'h35A);
      bus(1'b0, `UBD_OFS_TX, 32'h0);
      chk(v, 32'h5A);
      $display("transmit done");
   endtask : t_tx
   task automatic t_rx;
      give(9'h13C);
      chk(rx_full, 32'h1);
      bus(1'b1, `UBD_OFS_RX, 32'hFF);
      bus(1'b0, `UBD_OFS_RXS, 32'h0);
      chk(v, 32'h3);
      bus(1'b0, `UBD_OFS_RX, 32'h0);
      chk(v, 32'h3C);
      give(9'h0C3);
      bus(1'b0, `UBD_OFS_RX, 32'h0);
      chk(v, 32'hC3);
      bus(1'b0, `UBD_OFS_RXS, 32'h0);
      chk(v, 32'h0);
      $display("receive done");
   endtask : t_rx
   task automatic t_rates;
      bus(1'b1, `UBD_OFS_DIVL, 32'h2);
      bus(1'b1, `UBD_OFS_DIVH, 32'h1);
      for (i = 0; i < 6; i++) begin
         bus(1'b1, `UBD_OFS_BCTL, 32'(i % 2) << 3);
         bus(1'b1, `UBD_OFS_TXC, {24'h0, txc[i]});
         chk(sync_m, {31'h0, txc[i][`UBD_TXC_SYNC]});
         gap(1'b0);
         gap(1'b0);
         chk(n, (i % 2) ? 259 : 3);
         gap(1'b1);
         gap(1'b1);
         chk(n, fac[i] * ((i % 2) ? 259 : 3));
      end
      $display("rates done");
   endtask : t_rates
   task automatic t_restart(input logic [7:0] a);
      bus(1'b1, `UBD_OFS_DIVL, 32'd100);
      bus(1'b1, `UBD_OFS_DIVH, 32'h0);
      gap(1'b0);
      repeat (40) @(negedge clk);
      bus(1'b1, a, 32'h0 + (a == `UBD_OFS_DIVL ? 100 : 0));
      gap(1'b0);
      chk(n, 32'd101);
      $display("restart done");
   endtask : t_restart
   // ==========================================
   // stimulus
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      {rst, hsel, hwrite, send, take_en, htrans} = '0;
      {haddr, hwdata, schar} = '0;
      err_total = 0;
      n_checks = 0;
      rst = 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_tx();
      t_rx();
      t_rates();
      bus(1'b1, `UBD_OFS_BCTL, 32'h0);
      t_restart(`UBD_OFS_DIVL);
      bus(1'b1, `UBD_OFS_BCTL, 32'h8);
      t_restart(`UBD_OFS_DIVH);
      final_report();
   end
endmodule : ubd_core_tb
